// ===== ams_monitor.sv
// Top of the two-channel analog monitor: settings, selection, channel scaling
//
// How it works
// (R01) Two independent channels, each steered by its own select setting.
// (R02) Codes pick speeds, torque reference and feedforwards; code 06 reserved.
// (R03) Code 03 shows position error, zero outside position control.
// (R04) Code 04 shows position error after electronic gear conversion.
// (R05) Code 07 shows motor-to-load position error at 0.01 V per unit.
// (R06) Code 08 gives 5 V when positioned; code 0B gives 1 or 2 V.
// (R07) Code 0C gives 5 V once the position reference is fully issued.
// (R08) Code 0D shows external encoder speed as motor shaft value.
// (R09) Direct-drive motor switches speed scaling to 1 V per 100 min-1.
// (R10) Reset selects torque reference on one, motor speed on two.
// (R11) Output is minus (signal times gain times multiplier plus offset).
// (R12) Offsets take -10000..10000 in 0.1 V, reset zero, immediate.
// (R13) Multiplier takes -10000..10000 in 0.01 times, immediate.
// (R14) Output linear only within 8 V; beyond that flagged.
// (R15) Converter code saturates at full scale instead of wrapping.
module ams_monitor
  import ams_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire ams_cfg_t cfg_wdata,
  input wire ams_quant_t quant,
  input wire ams_mode_t ctrl_mode,
  input wire logic direct_drive,
  output ams_cfg_t cfg_rdata,
  output logic cfg_clamped,
  output ams_conn_t monitor_output_connector
);

  typedef struct packed {
    ams_cfg_t cfg;
    logic clamped;
    logic [1:0][39:0] picked;
    ams_conn_t conn;
  } ams_top_state_t;

  ams_top_state_t st_reg;
  ams_top_state_t st_next;
  ams_cfg_t cfg_clip;
  logic [1:0][3:0] ch_sel;
  logic [1:0][15:0] ch_off;
  logic [1:0][15:0] ch_code;
  logic [1:0] ch_beyond;
  logic any_clip;

  // Settings outside the documented range are pulled to the nearest end
  function automatic logic signed [15:0] ams_clamp(
    input logic signed [15:0] value
  );
    logic signed [15:0] res;
    res = value;
    if (value > AMS_SET_MAX) begin
      res = AMS_SET_MAX;
    end else if (value < AMS_SET_MIN) begin
      res = AMS_SET_MIN;
    end
    return res;
  endfunction : ams_clamp

  function automatic logic ams_out_of_range(
    input logic signed [15:0] value
  );
    return (value > AMS_SET_MAX) || (value < AMS_SET_MIN);
  endfunction : ams_out_of_range

  // Maps a select code to its quantity in units of 0.1 mV
  function automatic logic signed [39:0] ams_pick(
    input logic [3:0] sel,
    input ams_quant_t q,
    input ams_mode_t mode,
    input logic dd
  );
    logic signed [63:0] spd_gain;
    logic signed [63:0] w;
    logic signed [39:0] v;
    spd_gain = dd ? 64'(AMS_G_SPEED_DD) : 64'(AMS_G_SPEED); // R09
    w = '0;
    case (sel)
      AMS_SEL_MOTOR_SPEED: begin
        w = 64'(q.motor_speed) * spd_gain; // R02
      end
      AMS_SEL_SPEED_REF: begin
        w = 64'(q.speed_ref) * spd_gain; // R02
      end
      AMS_SEL_TORQUE_REF: begin
        w = 64'(q.torque_ref) * 64'(AMS_G_TORQUE); // R02
      end
      AMS_SEL_POS_ERR: begin
        if (mode == AMS_MODE_POSITION) begin
          w = 64'(q.pos_err) * 64'(AMS_G_POS_ERR); // R03
        end else begin
          w = '0; // R03
        end
      end
      AMS_SEL_POS_AMP_ERR: begin
        w = 64'(q.pos_amp_err) * 64'(AMS_G_ENC_ERR); // R04
      end
      AMS_SEL_POS_REF_SPEED: begin
        w = 64'(q.pos_ref_speed) * spd_gain; // R02
      end
      AMS_SEL_LOAD_POS_ERR: begin
        w = 64'(q.load_pos_err) * 64'(AMS_G_LOAD_ERR); // R05
      end
      AMS_SEL_POS_DONE: begin
        w = q.positioning_done ? 64'(AMS_LVL_5V) : '0; // R06
      end
      AMS_SEL_SPEED_FF: begin
        w = 64'(q.speed_ff) * spd_gain; // R02
      end
      AMS_SEL_TORQUE_FF: begin
        w = 64'(q.torque_ff) * 64'(AMS_G_TORQUE); // R02
      end
      AMS_SEL_ACTIVE_GAIN: begin
        w = q.second_gain ? 64'(AMS_LVL_2V) : 64'(AMS_LVL_1V); // R06
      end
      AMS_SEL_REF_ISSUED: begin
        w = q.ref_issued ? 64'(AMS_LVL_5V) : '0; // R07
      end
      AMS_SEL_EXT_ENC_SPEED: begin
        // No direct-drive switch here: already a shaft-referred value
        w = 64'(q.ext_enc_speed) * 64'(AMS_G_SPEED); // R08
      end
      default: begin
        // Reserved code and the two unused codes drive 0 V
        w = '0; // R02
      end
    endcase
    v = 40'(w);
    // Huge quantities clip here, a wrap would flip the output sign
    if (64'(v) != w) begin
      v = w[63] ? {1'b1, 39'h0} : {1'b0, {39{1'b1}}}; // R15
    end
    return v;
  endfunction : ams_pick

  // Incoming settings after range limiting
  always_comb begin
    cfg_clip = cfg_wdata;
    cfg_clip.monitor_one_offset = ams_clamp(cfg_wdata.monitor_one_offset); // R12
    cfg_clip.monitor_two_offset = ams_clamp(cfg_wdata.monitor_two_offset); // R12
    cfg_clip.monitor_multiplier = ams_clamp(cfg_wdata.monitor_multiplier); // R13
    any_clip = ams_out_of_range(cfg_wdata.monitor_one_offset)
      || ams_out_of_range(cfg_wdata.monitor_two_offset)
      || ams_out_of_range(cfg_wdata.monitor_multiplier);
  end

  // Per-channel views of the live settings
  always_comb begin
    ch_sel[0] = st_reg.cfg.monitor_one_select; // R01
    ch_sel[1] = st_reg.cfg.monitor_two_select; // R01
    ch_off[0] = st_reg.cfg.monitor_one_offset;
    ch_off[1] = st_reg.cfg.monitor_two_offset;
  end

  always_comb begin
    st_next = st_reg;
    if (cfg_wr) begin
      // New values steer the very next sample, no staging
      st_next.cfg = cfg_clip; // R12 R13
      st_next.clamped = any_clip;
    end
    for (int ch = 0; ch < 2; ch++) begin
      st_next.picked[ch] = ams_pick(ch_sel[ch], quant, ctrl_mode, direct_drive); // R01
    end
    st_next.conn.code_one = ch_code[0];
    st_next.conn.code_two = ch_code[1];
    st_next.conn.beyond_one = ch_beyond[0]; // R14
    st_next.conn.beyond_two = ch_beyond[1]; // R14
    if (sys_rst) begin
      st_next = '0;
      st_next.cfg.monitor_one_select = AMS_SEL_ONE_RST; // R10
      st_next.cfg.monitor_two_select = AMS_SEL_TWO_RST; // R10
      st_next.cfg.monitor_one_offset = AMS_OFFSET_RST; // R12
      st_next.cfg.monitor_two_offset = AMS_OFFSET_RST; // R12
      st_next.cfg.monitor_multiplier = AMS_MULT_RST; // R13
    end
  end

  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  // Both channels share the multiplier; offsets are per channel
  for (genvar g = 0; g < 2; g++) begin : g_ch
    ams_channel u_ch (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .picked(st_reg.picked[g]),
      .multiplier(st_reg.cfg.monitor_multiplier),
      .offset(ch_off[g]),
      .dac_code(ch_code[g]),
      .beyond_linear(ch_beyond[g])
    );
  end

  assign cfg_rdata = st_reg.cfg;
  assign cfg_clamped = st_reg.clamped;
  assign monitor_output_connector = st_reg.conn;

endmodule : ams_monitor

// ===== ams_pkg.sv
// Shared types and constants of the two-channel analog monitor scaler
package ams_pkg;

  // Monitor signal select codes
  typedef enum logic [3:0] {
    AMS_SEL_MOTOR_SPEED = 4'b0000,
    AMS_SEL_SPEED_REF = 4'b0001,
    AMS_SEL_TORQUE_REF = 4'b0010,
    AMS_SEL_POS_ERR = 4'b0011,
    AMS_SEL_POS_AMP_ERR = 4'b0100,
    AMS_SEL_POS_REF_SPEED = 4'b0101,
    AMS_SEL_RESERVED = 4'b0110,
    AMS_SEL_LOAD_POS_ERR = 4'b0111,
    AMS_SEL_POS_DONE = 4'b1000,
    AMS_SEL_SPEED_FF = 4'b1001,
    AMS_SEL_TORQUE_FF = 4'b1010,
    AMS_SEL_ACTIVE_GAIN = 4'b1011,
    AMS_SEL_REF_ISSUED = 4'b1100,
    AMS_SEL_EXT_ENC_SPEED = 4'b1101
  } ams_sel_t;

  typedef enum logic [1:0] {
    AMS_MODE_POSITION = 2'b00,
    AMS_MODE_SPEED = 2'b01,
    AMS_MODE_TORQUE = 2'b10
  } ams_mode_t;

  // Reset selections of the two channels
  localparam ams_sel_t AMS_SEL_ONE_RST = AMS_SEL_TORQUE_REF;
  localparam ams_sel_t AMS_SEL_TWO_RST = AMS_SEL_MOTOR_SPEED;
  localparam logic signed [15:0] AMS_OFFSET_RST = 16'h0000;
  localparam logic signed [15:0] AMS_MULT_RST = 16'h0064;

  // Setting ranges (offset in 0.1 V, multiplier in 0.01 times)
  localparam logic signed [15:0] AMS_SET_MAX = 16'h2710;
  localparam logic signed [15:0] AMS_SET_MIN = -16'sh2710;

  // Gains into the internal unit of 0.1 mV per input unit
  localparam logic signed [19:0] AMS_G_SPEED = 20'h0_000A;
  localparam logic signed [19:0] AMS_G_SPEED_DD = 20'h0_0064;
  localparam logic signed [19:0] AMS_G_TORQUE = 20'h0_0001;
  localparam logic signed [19:0] AMS_G_POS_ERR = 20'h0_01F4;
  localparam logic signed [19:0] AMS_G_ENC_ERR = 20'h0_01F4;
  localparam logic signed [19:0] AMS_G_LOAD_ERR = 20'h0_0064;
  localparam logic signed [19:0] AMS_LVL_1V = 20'h0_2710;
  localparam logic signed [19:0] AMS_LVL_2V = 20'h0_4E20;
  localparam logic signed [19:0] AMS_LVL_5V = 20'h0_C350;

  // Offset step of 0.1 V expressed in microvolts
  localparam logic signed [19:0] AMS_OFFSET_UV = 20'h1_86A0;

  // Converter: 16-bit signed code, +/-10 V full scale
  localparam logic signed [15:0] AMS_DAC_MAX = 16'h7FFF;
  localparam logic signed [15:0] AMS_DAC_MIN = 16'h8000;
  localparam logic [15:0] AMS_DAC_K = 16'h0D6C;
  localparam int unsigned AMS_DAC_SHIFT = 20;
  localparam logic [15:0] AMS_FS_MV = 16'h2710;
  localparam logic [15:0] AMS_LINEAR_MV = 16'h1F40;
  localparam logic [15:0] AMS_LINEAR_CODE =
    16'((32'(AMS_LINEAR_MV) * 32'h0000_8000) / 32'(AMS_FS_MV));

  typedef struct packed {
    logic signed [31:0] motor_speed;
    logic signed [31:0] speed_ref;
    logic signed [31:0] torque_ref;
    logic signed [31:0] pos_err;
    logic signed [31:0] pos_amp_err;
    logic signed [31:0] pos_ref_speed;
    logic signed [31:0] load_pos_err;
    logic signed [31:0] speed_ff;
    logic signed [31:0] torque_ff;
    logic signed [31:0] ext_enc_speed;
    logic positioning_done;
    logic second_gain;
    logic ref_issued;
  } ams_quant_t;

  typedef struct packed {
    ams_sel_t monitor_one_select;
    ams_sel_t monitor_two_select;
    logic signed [15:0] monitor_one_offset;
    logic signed [15:0] monitor_two_offset;
    logic signed [15:0] monitor_multiplier;
  } ams_cfg_t;

  typedef struct packed {
    logic signed [15:0] code_one;
    logic signed [15:0] code_two;
    logic beyond_one;
    logic beyond_two;
  } ams_conn_t;

endpackage : ams_pkg

// ===== ams_channel.sv
// One monitor channel: multiplier, offset, negation, converter code
module ams_channel
  import ams_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic signed [39:0] picked,
  input wire logic signed [15:0] multiplier,
  input wire logic signed [15:0] offset,
  output logic signed [15:0] dac_code,
  output logic beyond_linear
);

  typedef struct packed {
    logic signed [56:0] sum;
    logic signed [15:0] code;
    logic beyond;
  } ams_ch_state_t;

  ams_ch_state_t st_reg;
  ams_ch_state_t st_next;
  logic signed [57:0] neg;
  logic signed [73:0] scaled;
  logic signed [73:0] code_full;
  logic signed [15:0] abs_code;

  always_comb begin
    st_next = st_reg;
    // Microvolts: picked is 0.1 mV, multiplier 0.01x, so no divider needed
    st_next.sum = 57'(picked) * 57'(multiplier)
      + 57'(offset) * 57'(AMS_OFFSET_UV); // R11 R12 R13
    // Extra bit keeps the most negative sum from overflowing on negation
    neg = -58'(st_reg.sum); // R11
    scaled = 74'(neg) * 74'($signed({1'b0, AMS_DAC_K}));
    code_full = scaled >>> AMS_DAC_SHIFT;
    if (code_full > 74'(AMS_DAC_MAX)) begin
      st_next.code = AMS_DAC_MAX; // R15
    end else if (code_full < 74'(AMS_DAC_MIN)) begin
      st_next.code = AMS_DAC_MIN; // R15
    end else begin
      st_next.code = code_full[15:0];
    end
    abs_code = st_reg.code[15] ? -st_reg.code : st_reg.code;
    // Most negative code has no positive twin, still beyond
    st_next.beyond = (st_reg.code == AMS_DAC_MIN)
      || (abs_code > $signed(AMS_LINEAR_CODE)); // R14
    if (sys_rst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  assign dac_code = st_reg.code;
  assign beyond_linear = st_reg.beyond;

endmodule : ams_channel

// ===== ams_monitor_sva.sv
// Port checks of the two-channel analog monitor
module ams_monitor_sva
  import ams_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire ams_cfg_t cfg_wdata,
  input wire ams_quant_t quant,
  input wire ams_mode_t ctrl_mode,
  input wire logic direct_drive,
  input wire ams_cfg_t cfg_rdata,
  input wire logic cfg_clamped,
  input wire ams_conn_t monitor_output_connector
);
  wire ams_conn_t mc = monitor_output_connector;
  localparam int LIM = int'(AMS_LINEAR_CODE);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_reset;
    disable iff (1'b0) sys_rst |=> !cfg_clamped && mc.code_one == 16'h0000 &&
      mc.code_two == 16'h0000 && !mc.beyond_one && !mc.beyond_two &&
      cfg_rdata == ams_cfg_t'{AMS_SEL_TORQUE_REF, AMS_SEL_MOTOR_SPEED, 16'h0000,
      16'h0000, AMS_MULT_RST};
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_sel_write;
    cfg_wr |=> cfg_rdata.monitor_one_select == $past(cfg_wdata.monitor_one_select) &&
      cfg_rdata.monitor_two_select == $past(cfg_wdata.monitor_two_select);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select not taken");
  property p_mult_clamp;
    cfg_wr && cfg_wdata.monitor_multiplier < AMS_SET_MIN |=>
      cfg_rdata.monitor_multiplier == AMS_SET_MIN && cfg_clamped;
  endproperty
  a_mult_clamp: assert property (p_mult_clamp) else $error("multiplier clamp");
  property p_off_clamp;
    cfg_wr && cfg_wdata.monitor_one_offset > AMS_SET_MAX |=>
      cfg_rdata.monitor_one_offset == AMS_SET_MAX && cfg_clamped;
  endproperty
  a_off_clamp: assert property (p_off_clamp) else $error("offset clamp");
  property p_beyond;
    1'b1 |=> mc.beyond_one == (int'($past(mc.code_one)) > LIM ||
      int'($past(mc.code_one)) < -LIM);
  endproperty
  a_beyond: assert property (p_beyond) else $error("linear range flag");
  property p_pos_err_zero;
    (cfg_rdata.monitor_one_select == AMS_SEL_POS_ERR && ctrl_mode != AMS_MODE_POSITION &&
      cfg_rdata.monitor_one_offset == 16'h0000) [*6] |=> mc.code_one == 16'h0000;
  endproperty
  a_pos_err_zero: assert property (p_pos_err_zero) else $error("pos error not 0");
  property p_done_5v;
    (cfg_rdata.monitor_one_select == AMS_SEL_POS_DONE && quant.positioning_done &&
      cfg_rdata.monitor_multiplier == 16'h0064 && cfg_rdata.monitor_one_offset == 16'h0000)
      [*6] |=> mc.code_one == 16'hBFFF;
  endproperty
  a_done_5v: assert property (p_done_5v) else $error("done level wrong");
  property p_reserved;
    (cfg_rdata.monitor_two_select == AMS_SEL_RESERVED &&
      cfg_rdata.monitor_two_offset == 16'h0000) [*6] |=> mc.code_two == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not 0");
endmodule : ams_monitor_sva

// ===== ams_recorder.sv
// Recorder on the monitor connector, channel one in millivolts
module ams_recorder
  import ams_pkg::*;
(
  input wire ams_conn_t monitor_output_connector,
  output int mv_one,
  output logic linear_one
);
  always_comb begin
    mv_one = int'(monitor_output_connector.code_one) * int'(AMS_FS_MV) / 32'sh0000_8000;
    // Readings past the linear band drive linear_one low
    linear_one = mv_one <= int'(AMS_LINEAR_MV) && mv_one >= -int'(AMS_LINEAR_MV);
  end
endmodule : ams_recorder

// ===== tb.sv
// Self-checking bench of the two-channel analog monitor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ams_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_wr = 1'b0;
  ams_cfg_t cfg_wdata = '0;
  ams_quant_t quant = '0;
  ams_mode_t ctrl_mode = AMS_MODE_POSITION;
  logic direct_drive = 1'b0;
  ams_cfg_t cfg_rdata;
  logic cfg_clamped;
  ams_conn_t mc;
  int mv_one;
  logic linear_one;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  ams_monitor i_ams_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .quant(quant), .ctrl_mode(ctrl_mode),
    .direct_drive(direct_drive), .cfg_rdata(cfg_rdata), .cfg_clamped(cfg_clamped),
    .monitor_output_connector(mc));
  ams_recorder i_ams_recorder (.monitor_output_connector(mc), .mv_one(mv_one),
    .linear_one(linear_one));
  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Settings write, then long enough for the code to settle
  task automatic put_cfg(input ams_cfg_t c);
    cfg_wr = 1'b1;
    cfg_wdata = c;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask : put_cfg
  function automatic logic signed [15:0] exp_code(input longint uv);
    longint p;
    p = (-uv * longint'(AMS_DAC_K)) >>> AMS_DAC_SHIFT;
    if (p > longint'(AMS_DAC_MAX))
      p = longint'(AMS_DAC_MAX);
    if (p < longint'(AMS_DAC_MIN))
      p = longint'(AMS_DAC_MIN);
    return 16'(p);
  endfunction : exp_code
  // Selected quantity in units of 0.1 mV
  function automatic longint exp_pick(input logic [3:0] s);
    longint g;
    g = direct_drive ? AMS_G_SPEED_DD : AMS_G_SPEED;
    case (s)
      4'h0: return quant.motor_speed * g;
      4'h1: return quant.speed_ref * g;
      4'h2: return quant.torque_ref * AMS_G_TORQUE;
      4'h3: if (ctrl_mode == AMS_MODE_POSITION) return quant.pos_err * AMS_G_POS_ERR;
      4'h4: return quant.pos_amp_err * AMS_G_ENC_ERR;
      4'h5: return quant.pos_ref_speed * g;
      4'h7: return quant.load_pos_err * AMS_G_LOAD_ERR;
      4'h8: if (quant.positioning_done) return AMS_LVL_5V;
      4'h9: return quant.speed_ff * g;
      4'hA: return quant.torque_ff * AMS_G_TORQUE;
      4'hB: return quant.second_gain ? AMS_LVL_2V : AMS_LVL_1V;
      4'hC: if (quant.ref_issued) return AMS_LVL_5V;
      4'hD: return quant.ext_enc_speed * AMS_G_SPEED;
      default: ;
    endcase
    return 64'sh0;
  endfunction : exp_pick
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 32'h0000_07D0) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk("cfg_rdata", ams_cfg_t'{AMS_SEL_TORQUE_REF, AMS_SEL_MOTOR_SPEED, 16'h0000,
      16'h0000, 16'h0064}, cfg_rdata);
    chk("code_one", '0, mc.code_one);
    chk("linear_one", 1'b1, linear_one);
    quant.motor_speed = 32'sh0000_03E8;
    quant.speed_ref = -32'sh0000_07D0;
    quant.torque_ref = 32'sh0000_1388;
    quant.pos_err = 32'sh0000_0007;
    quant.pos_amp_err = -32'sh0000_0003;
    quant.pos_ref_speed = 32'sh0000_05DC;
    quant.load_pos_err = 32'sh0000_0028;
    quant.speed_ff = -32'sh0000_01F4;
    quant.torque_ff = -32'sh0000_1B58;
    quant.ext_enc_speed = 32'sh0000_0BB8;
    // Second pass: speed control, direct drive, flags inverted
    for (int p = 0; p < 2; p++) begin
      ctrl_mode = p ? AMS_MODE_SPEED : AMS_MODE_POSITION;
      direct_drive = p[0];
      quant.positioning_done = !p[0];
      quant.second_gain = p[0];
      quant.ref_issued = p[0];
      for (int s = 0; s < 16; s++) begin
        put_cfg(ams_cfg_t'{ams_sel_t'(s), ams_sel_t'(15 - s), 16'h0000, 16'h0000, 16'h0064});
        chk("code_one", exp_code(exp_pick(4'(s)) * 64'sh64), mc.code_one);
        chk("code_two", exp_code(exp_pick(4'(15 - s)) * 64'sh64), mc.code_two);
      end
    end
    direct_drive = 1'b0;
    ctrl_mode = AMS_MODE_TORQUE;
    put_cfg(ams_cfg_t'{AMS_SEL_POS_ERR, AMS_SEL_POS_AMP_ERR, 16'h0000, 16'h0032, 16'h0064});
    chk("code_one", 16'h0000, mc.code_one);
    chk("code_two", exp_code(exp_pick(4'h4) * 64'sh64 + 64'sh4C_4B40), mc.code_two);
    chk("beyond_two", 1'b0, mc.beyond_two);
    put_cfg(ams_cfg_t'{AMS_SEL_MOTOR_SPEED, AMS_SEL_TORQUE_REF, 16'hFFCE, 16'h0000, 16'h00C8});
    chk("code_one", exp_code(exp_pick(4'h0) * 64'shC8 - 64'sh4C_4B40), mc.code_one);
    chk("code_two", exp_code(exp_pick(4'h2) * 64'shC8), mc.code_two);
    chk("cfg_clamped", 1'b0, cfg_clamped);
    put_cfg(ams_cfg_t'{AMS_SEL_MOTOR_SPEED, AMS_SEL_TORQUE_REF, 16'h4E20, 16'hD8F0, 16'h8000});
    chk("cfg_rdata", ams_cfg_t'{AMS_SEL_MOTOR_SPEED, AMS_SEL_TORQUE_REF, 16'h2710,
      16'hD8F0, 16'hD8F0}, cfg_rdata);
    chk("cfg_clamped", 1'b1, cfg_clamped);
    chk("code_one", exp_code(exp_pick(4'h0) * -64'sh2710 + 64'sh3B9A_CA00), mc.code_one);
    chk("code_two", exp_code(exp_pick(4'h2) * -64'sh2710 - 64'sh3B9A_CA00), mc.code_two);
    chk("beyond_one", 1'b1, mc.beyond_one);
    chk("beyond_two", 1'b1, mc.beyond_two);
    chk("linear_one", 1'b0, linear_one);
    // Reset in mid-run must bring back every default
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk("cfg_rdata", ams_cfg_t'{AMS_SEL_TORQUE_REF, AMS_SEL_MOTOR_SPEED, 16'h0000,
      16'h0000, 16'h0064}, cfg_rdata);
    chk("cfg_clamped", 1'b0, cfg_clamped);
    chk("code_two", '0, mc.code_two);
    give_verdict();
  end
endmodule : tb
bind ams_monitor ams_monitor_sva i_ams_monitor_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .quant(quant), .ctrl_mode(ctrl_mode),
  .direct_drive(direct_drive), .cfg_rdata(cfg_rdata), .cfg_clamped(cfg_clamped),
  .monitor_output_connector(monitor_output_connector));
